// ===== logic/refcfg_defines.svh
`ifndef REFCFG_DEFINES_SVH
`define REFCFG_DEFINES_SVH
// register word indices; byte address is four times the index
`define IDX_POWER_DOWN 12'h500
`define IDX_FAMILY_AB 12'h501
`define IDX_FAMILY_CD 12'h502
`define IDX_ASSIGN_A 12'h503
`define IDX_ASSIGN_B 12'h504
`define IDX_ASSIGN_C 12'h505
`define IDX_ASSIGN_D 12'h506
`define IDX_PRIORITY 12'h508
`define IDX_STATUS 12'h509
// reset values
`define RST_REG8 8'h00
`define RST_PRIO 24'h000000
// field positions inside an assignment byte
`define FLD_SECOND_EN 7
`define FLD_SECOND_PROF_HI 6
`define FLD_SECOND_PROF_LO 4
`define FLD_FIRST_EN 3
`define FLD_FIRST_PROF_HI 2
`define FLD_FIRST_PROF_LO 0
// logic family codes
`define FAM_OFF_OR_DIFF 2'h0
`define FAM_CMOS_LOW 2'h1
`define FAM_CMOS_MID 2'h2
`define FAM_CMOS_HIGH 2'h3
// all receivers powered down
`define PD_ALL 8'hFF
`endif

// ===== logic/refcfg_pkg.sv
package refcfg_pkg;
	// receiver electrical mode
	typedef enum logic [2:0] {
		RX_OFF = 3'h0,
		RX_DIFF = 3'h1,
		RX_CMOS_LOW = 3'h3,
		RX_CMOS_MID = 3'h2,
		RX_CMOS_HIGH = 3'h6
	} rx_mode_e;
	// one assignment byte
	typedef struct packed {
		logic second_en;
		logic [2:0] second_prof;
		logic first_en;
		logic [2:0] first_prof;
	} assign_s;
	// whole register state
	typedef struct packed {
		logic [7:0] power_down;
		logic [7:0] family_ab;
		logic [7:0] family_cd;
		assign_s [3:0] assign_r;
		logic [23:0] prio;
		logic [31:0] rdata;
		logic ack;
		logic deep_sleep;
		logic [23:0] profile;
		logic [7:0] manual;
		logic [7:0] rx_on;
		logic [23:0] mode;
	} state_s;
endpackage : refcfg_pkg

// ===== logic/reference_input_config.sv
// What this block does
// - all eight powered down gives deep sleep
// - power-down bit one stops its receiver
// - second input family: off or CMOS range
// - second field ignored when first is 00
// - first field 00 makes pair differential
// - family fields packed in two bytes
// - mode bit: 0 automatic, 1 manual
// - manual profile number is plain binary
// - assignment bytes per pair, A to D
// - each profile has 3-bit priority, stored for readback only
`include "refcfg_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module reference_input_config (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic [13:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic [7:0] AUTO_PROFILE_0,
	input wire logic [7:0] AUTO_PROFILE_1,
	input wire logic [7:0] AUTO_PROFILE_2,
	input wire logic [7:0] AUTO_PROFILE_3,
	input wire logic [7:0] AUTO_PROFILE_4,
	input wire logic [7:0] AUTO_PROFILE_5,
	input wire logic [7:0] AUTO_PROFILE_6,
	input wire logic [7:0] AUTO_PROFILE_7,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic DEEP_SLEEP,
	output logic [7:0] RX_ENABLE,
	output logic [23:0] RX_MODE,
	output logic [23:0] REF_PROFILE,
	output logic [7:0] REF_MANUAL
);
	refcfg_pkg::state_s s_q; // all state
	refcfg_pkg::state_s s_d; // next state
	logic [11:0] idx; // word index
	logic req; // fresh access
	logic [2:0] auto_prof [8]; // hardware-chosen profile per reference
	logic [2:0] chosen; // profile bound to reference
	logic [1:0] fam_first; // first-input family of the pair
	logic [1:0] fam_own; // this input's family
	logic [2:0] idx3; // temp
	logic [2:0] mode_v; // temp mode
	assign idx = WB_ADR_I[13:2];
	// second cycle of a held request must not ack twice
	assign req = WB_CYC_I && WB_STB_I && !s_q.ack;
	// external automatic choice enters as low three bits
	assign auto_prof[0] = AUTO_PROFILE_0[2:0];
	assign auto_prof[1] = AUTO_PROFILE_1[2:0];
	assign auto_prof[2] = AUTO_PROFILE_2[2:0];
	assign auto_prof[3] = AUTO_PROFILE_3[2:0];
	assign auto_prof[4] = AUTO_PROFILE_4[2:0];
	assign auto_prof[5] = AUTO_PROFILE_5[2:0];
	assign auto_prof[6] = AUTO_PROFILE_6[2:0];
	assign auto_prof[7] = AUTO_PROFILE_7[2:0];

	// register writes, readback, and decoded outputs
	always_comb begin
		s_d = s_q;
		chosen = 3'h0;
		fam_first = 2'h0;
		fam_own = 2'h0;
		idx3 = 3'h0;
		mode_v = refcfg_pkg::RX_OFF;
		s_d.ack = req;
		s_d.rdata = 32'h00000000;
		if (req && WB_WE_I && WB_SEL_I[0]) begin
			// only the low lane carries register data
			unique case (idx)
				`IDX_POWER_DOWN: s_d.power_down = WB_DAT_I[7:0];
				`IDX_FAMILY_AB: s_d.family_ab = WB_DAT_I[7:0];
				`IDX_FAMILY_CD: s_d.family_cd = WB_DAT_I[7:0];
				`IDX_ASSIGN_A: s_d.assign_r[0] = WB_DAT_I[7:0];
				`IDX_ASSIGN_B: s_d.assign_r[1] = WB_DAT_I[7:0];
				`IDX_ASSIGN_C: s_d.assign_r[2] = WB_DAT_I[7:0];
				`IDX_ASSIGN_D: s_d.assign_r[3] = WB_DAT_I[7:0];
				default: ;
			endcase
		end
		// priority word uses three lanes
		if (req && WB_WE_I && idx == `IDX_PRIORITY) begin
			if (WB_SEL_I[0]) s_d.prio[7:0] = WB_DAT_I[7:0];
			if (WB_SEL_I[1]) s_d.prio[15:8] = WB_DAT_I[15:8];
			if (WB_SEL_I[2]) s_d.prio[23:16] = WB_DAT_I[23:16];
		end
		// reads; unmapped answer zero with ack
		if (req && !WB_WE_I) begin
			unique case (idx)
				`IDX_POWER_DOWN: s_d.rdata[7:0] = s_q.power_down;
				`IDX_FAMILY_AB: s_d.rdata[7:0] = s_q.family_ab;
				`IDX_FAMILY_CD: s_d.rdata[7:0] = s_q.family_cd;
				`IDX_ASSIGN_A: s_d.rdata[7:0] = s_q.assign_r[0];
				`IDX_ASSIGN_B: s_d.rdata[7:0] = s_q.assign_r[1];
				`IDX_ASSIGN_C: s_d.rdata[7:0] = s_q.assign_r[2];
				`IDX_ASSIGN_D: s_d.rdata[7:0] = s_q.assign_r[3];
				`IDX_PRIORITY: s_d.rdata[23:0] = s_q.prio;
				`IDX_STATUS: s_d.rdata[7:0] = {7'h00, s_q.deep_sleep};
				default: ;
			endcase
		end
		// outputs decode from the committed register values
		s_d.deep_sleep = (s_q.power_down == `PD_ALL);
		for (int r = 0; r < 8; r++) begin
			// reference r: pair r/2, member r%2 (1 = second)
			idx3 = 3'(r);
			if (idx3[2]) begin
				fam_first = s_q.family_cd[(r % 4) / 2 * 4 +: 2];
				fam_own = s_q.family_cd[(r % 4) * 2 +: 2];
			end else begin
				fam_first = s_q.family_ab[(r % 4) / 2 * 4 +: 2];
				fam_own = s_q.family_ab[(r % 4) * 2 +: 2];
			end
			if (idx3[0]) begin
				// second member: ignored when pair is differential
				if (fam_first == `FAM_OFF_OR_DIFF) mode_v = refcfg_pkg::RX_OFF;
				else begin
					unique case (fam_own)
						`FAM_OFF_OR_DIFF: mode_v = refcfg_pkg::RX_OFF;
						`FAM_CMOS_LOW: mode_v = refcfg_pkg::RX_CMOS_LOW;
						`FAM_CMOS_MID: mode_v = refcfg_pkg::RX_CMOS_MID;
						`FAM_CMOS_HIGH: mode_v = refcfg_pkg::RX_CMOS_HIGH;
					endcase
				end
			end else begin
				unique case (fam_own)
					`FAM_OFF_OR_DIFF: mode_v = refcfg_pkg::RX_DIFF;
					`FAM_CMOS_LOW: mode_v = refcfg_pkg::RX_CMOS_LOW;
					`FAM_CMOS_MID: mode_v = refcfg_pkg::RX_CMOS_MID;
					`FAM_CMOS_HIGH: mode_v = refcfg_pkg::RX_CMOS_HIGH;
				endcase
			end
			s_d.mode[r * 3 +: 3] = mode_v;
			// powered-down or unused receivers are not enabled
			s_d.rx_on[r] = !s_q.power_down[r] && (mode_v != refcfg_pkg::RX_OFF)
				&& (s_q.power_down != `PD_ALL);
			// manual versus automatic profile binding
			if (idx3[0]) begin
				s_d.manual[r] = s_q.assign_r[r / 2].second_en;
				chosen = s_q.assign_r[r / 2].second_prof;
			end else begin
				s_d.manual[r] = s_q.assign_r[r / 2].first_en;
				chosen = s_q.assign_r[r / 2].first_prof;
			end
			if (!s_d.manual[r]) chosen = auto_prof[r];
			s_d.profile[r * 3 +: 3] = chosen;
		end
	end

	// single register stage; async clear to zero
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs taken straight from flops
	assign WB_DAT_O = s_q.rdata;
	assign WB_ACK_O = s_q.ack;
	assign DEEP_SLEEP = s_q.deep_sleep;
	assign RX_ENABLE = s_q.rx_on;
	assign RX_MODE = s_q.mode;
	assign REF_PROFILE = s_q.profile;
	assign REF_MANUAL = s_q.manual;
endmodule : reference_input_config
`default_nettype wire

// ===== verification/refcfg_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// watches the register port and the decoded receiver outputs
module refcfg_assertions (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic [7:0] AUTO_PROFILE_0,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic DEEP_SLEEP,
	input wire logic [7:0] RX_ENABLE,
	input wire logic [23:0] RX_MODE,
	input wire logic [23:0] REF_PROFILE,
	input wire logic [7:0] REF_MANUAL
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	ack_take_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
	ack_idle_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O) else $error("stray ack");
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
	rdata_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data idle");
	sleep_off_a: assert property (DEEP_SLEEP |-> RX_ENABLE == 8'h00) else $error("awake rx");
	rx_mode_a: assert property (RX_ENABLE[0] |-> RX_MODE[2:0] != 3'h0) else $error("rx off on");
	diff_pair_a: assert property (RX_MODE[2:0] == 3'h1 |-> RX_MODE[5:3] == 3'h0) else $error("pair");
	// auto choice lands one cycle after the selector input
	auto_prof_a: assert property ($past(RSTN) && !REF_MANUAL[0] |->
		REF_PROFILE[2:0] == $past(AUTO_PROFILE_0[2:0])) else $error("auto prof");
endmodule : refcfg_assertions
bind reference_input_config refcfg_assertions u_refcfg_assertions (.*);
`default_nettype wire

// ===== verification/refcfg_auto_src.sv
`timescale 1ns/1ps
`default_nettype none
// automatic selector stand-in; a real one moves rarely, so values stand until reloaded
module refcfg_auto_src (
	input wire logic clk,
	input wire logic load,
	input wire logic [63:0] nxt,
	output logic [63:0] prof
);
	initial prof = 64'h0;
	// one byte per reference, low three bits are the profile
	always @(posedge clk) begin
		if (load) begin
			prof <= nxt;
		end
	end
endmodule : refcfg_auto_src
`default_nettype wire

// ===== verification/tb_reference_input_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_reference_input_config;
	logic mclk = 0, rstn = 0, we = 0, cyc = 0, ld = 0, ack, slp;
	logic [13:0] adr = 0;
	logic [31:0] wd = 0, rdat;
	logic [63:0] nx = 0, ap;
	logic [7:0] rxe, man, v[8];
	logic [23:0] rxm, prf;
	logic [7:0] q[$]; // expected read bytes, oldest first
	logic [7:0] pdv[3] = '{8'h01, 8'hFF, 8'hFE};
	logic [7:0] asv[2] = '{8'hF5, 8'h08};
	integer mismatches = 0, tests_run = 0, seed = 32'h8DCA9F8D, i;
	refcfg_auto_src u_refcfg_auto_src (.clk(mclk), .load(ld), .nxt(nx), .prof(ap));
	reference_input_config u_reference_input_config (.MCLK(mclk), .RSTN(rstn), .WB_ADR_I(adr),
		.WB_DAT_I(wd), .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.AUTO_PROFILE_0(ap[7:0]), .AUTO_PROFILE_1(ap[15:8]), .AUTO_PROFILE_2(ap[23:16]),
		.AUTO_PROFILE_3(ap[31:24]), .AUTO_PROFILE_4(ap[39:32]), .AUTO_PROFILE_5(ap[47:40]),
		.AUTO_PROFILE_6(ap[55:48]), .AUTO_PROFILE_7(ap[63:56]), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.DEEP_SLEEP(slp), .RX_ENABLE(rxe), .RX_MODE(rxm), .REF_PROFILE(prf), .REF_MANUAL(man));
	initial forever #4 mclk = ~mclk;
	task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	// classic cycle, held until ack is sampled high
	task automatic wb(logic w, logic [11:0] x, logic [7:0] d);
		@(posedge mclk);
		cyc <= 1; we <= w; adr <= {x, 2'h0}; wd <= {24'h0, d};
		do @(posedge mclk); while (ack !== 1'b1);
		cyc <= 0;
	endtask : wb
	task automatic rd_chk(logic [11:0] x, logic [7:0] e);
		q.push_back(e);
		wb(0, x, 8'h00);
	endtask : rd_chk
	// decoded outputs move one edge after the ack
	task automatic settle;
		repeat (2) @(posedge mclk);
		#1;
	endtask : settle
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim
	// read answers checked against the oldest note
	always @(posedge mclk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			cmp("rdata", {24'h0, q.pop_front()}, rdat);
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1;
		for (i = 0; i < 8; i++) rd_chk(12'h500 + i, 8'h00);
		for (i = 0; i < 8; i++) begin
			v[i] = $random(seed);
			wb(1, 12'h500 + i, v[i]);
		end
		// the eighth index is unmapped and must stay zero
		for (i = 0; i < 8; i++) rd_chk(12'h500 + i, i < 7 ? v[i] : 8'h00);
		wb(1, 12'h500, 8'h00);
		wb(1, 12'h501, 8'hE4);
		wb(1, 12'h502, 8'h1B);
		settle;
		cmp("mode", {12'h0D6, 12'hC81}, rxm);
		// priority word: low lane written, upper lanes cleared by zero data
		wb(1, 12'h508, 8'hA5);
		rd_chk(12'h508, 8'hA5);
		for (i = 0; i < 3; i++) begin
			wb(1, 12'h500, pdv[i]);
			settle;
			cmp("rx_on", 8'h7D & ~pdv[i], rxe);
			cmp("sleep", pdv[i] == 8'hFF, slp);
			rd_chk(12'h509, {7'h00, pdv[i] == 8'hFF});
		end
		for (i = 0; i < 2; i++) begin
			@(posedge mclk);
			nx <= {$random(seed), $random(seed)};
			ld <= 1;
			@(posedge mclk);
			ld <= 0;
			wb(1, 12'h503, asv[i]);
			settle;
			cmp("prof", i ? {ap[10:8], 3'h0} : {3'h7, ap[2:0]}, prf[5:0]);
			cmp("manual", i ? 2'h1 : 2'h2, man[1:0]);
			rd_chk(12'h503, asv[i]);
		end
		settle;
		end_sim;
	end
	// cut a hang well past the expected run
	initial begin
		#100000;
		mismatches++;
		end_sim;
	end
endmodule : tb_reference_input_config
`default_nettype wire
